// ---- rtl/srp_burst_ctr.sv ----
/*
  Two-bit burst counter producing the low address bits of each beat.
  Assumes load and step come from logic on the same clock.
*/
`include "srp_regs.svh"
module srp_burst_ctr (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_load,
  input wire logic i_step,
  input wire logic [1:0] i_start_lo,
  input wire logic i_linear,
  // Result
  output logic [1:0] o_lo,
  output logic [1:0] o_cnt
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] base_q;
  logic [1:0] base_d;

  // Both orders stay inside the four-word group
  function automatic logic [1:0] burst_lo(input logic [1:0] base, input logic [1:0] cnt,
                                          input logic linear);
    burst_lo = linear ? (base + cnt) : (base ^ cnt);
  endfunction

  assign cnt_d = i_load ? `SRP_CNT_ZERO : (i_step ? cnt_q + `SRP_CNT_ONE : cnt_q);
  assign base_d = i_load ? i_start_lo : base_q;
  assign o_lo = burst_lo(base_d, cnt_d, i_linear);
  assign o_cnt = cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= `SRP_CNT_ZERO;
      base_q <= `SRP_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
      base_q <= base_d;
    end
  end
endmodule

// ---- rtl/srp_fifo.sv ----
/*
  Register-based FIFO with valid/ready on both sides and an occupancy count.
  Assumes one clock; DEPTH is a power of two.
*/
module srp_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready,
  // Occupancy
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  wire push = i_valid & o_ready;
  wire pop = o_valid & i_ready;

  assign o_ready = (count_q != FULL);
  assign o_valid = (count_q != '0);
  assign o_data = mem[rd_ptr_q];
  assign o_level = count_q;
  assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, push};
      rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, pop};
      count_q <= count_d;
    end
  end
endmodule

// ---- rtl/srp_pkg.sv ----
/*
  Types shared by the SRAM port modules: bus control bundle, data word, states.
  Assumes srp_regs.svh is on the include path.
*/
package srp_pkg;
  `include "srp_regs.svh"

  typedef logic [`SRP_WORD_W-1:0] srp_word_t;

  typedef struct packed {
    logic [`SRP_AW-1:0] addr;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic pipe_chip_en_n;
    logic depth_chip_en;
    logic depth_chip_en_n;
    logic [`SRP_LANES-1:0] byte_lane_write_n;
    logic byte_write_enable_n;
    logic all_bytes_write_n;
  } srp_ctl_t;

  typedef enum logic [1:0] {
    SRP_IDLE = 2'b01,
    SRP_BURST = 2'b10
  } srp_state_t;
endpackage

// ---- rtl/srp_port.sv ----
/*
  Bus-side port of a pipelined burst SRAM: input registers, burst control,
  self-timed byte writes, output register and a read-beat stream FIFO.
  Assumes the master drives i_ctl and i_dq synchronously to i_clk; out enable,
  sleep and the order select are asynchronous levels.
*/
`include "srp_regs.svh"

// Notes on behaviour
// - Register every synchronous input on rising edge
// - Inputs and read data both pass registers
// - Either address strobe latches address and enables
// - Later addresses internal, step only on advance
// - Two-bit burst counter makes beat sequence
// - Interleaved or linear order, user selected
// - First data three cycles, then one each
// - Writes registered, array write self-timed
// - Per-byte controls select written lanes
// - Global write low writes all lanes
// - Output enable and sleep act asynchronously
// - Low two address bits load counter
// - Start only with strobe and enables active
module srp_port (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Synchronous bus controls and data
  input wire srp_pkg::srp_ctl_t i_ctl,
  input wire srp_pkg::srp_word_t i_dq,
  // Data pins
  output srp_pkg::srp_word_t o_dq,
  output logic o_dq_oe,
  // Asynchronous controls
  input wire logic i_out_en_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_linear,
  // Read beat stream
  output srp_pkg::srp_word_t o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic o_port_stall
);
  import srp_pkg::*;

  srp_ctl_t ctl_q;
  srp_word_t din_q;
  logic slp_s1_q;
  logic slp_s2_q;
  logic mode_s1_q;
  logic mode_s2_q;
  srp_state_t state_q;
  srp_state_t state_d;
  logic [`SRP_AW-1:2] base_q;
  logic [`SRP_AW-1:0] b_addr_q;
  logic [`SRP_LANES-1:0] b_mask_q;
  srp_word_t b_data_q;
  logic b_rd_q;
  srp_word_t dout_q;
  logic rdv_q;
  srp_word_t mem [0:(1<<`SRP_MEM_AW)-1];
  logic [1:0] ctr_lo;
  logic [1:0] ctr_cnt;
  logic fifo_in_ready;
  logic [`SRP_FIFO_CW-1:0] fifo_level;

  // Lane mask of one cycle's write controls; global write overrides lanes
  function automatic logic [`SRP_LANES-1:0] lane_mask(input srp_ctl_t c);
    if (!c.all_bytes_write_n) begin
      lane_mask = `SRP_MASK_ALL;
    end else if (!c.byte_write_enable_n) begin
      lane_mask = ~c.byte_lane_write_n;
    end else begin
      lane_mask = `SRP_MASK_NONE;
    end
  endfunction

  wire strobe = !ctl_q.proc_addr_strobe_n || !ctl_q.ctrl_addr_strobe_n;
  wire ce_ok = !ctl_q.pipe_chip_en_n && ctl_q.depth_chip_en && !ctl_q.depth_chip_en_n;
  wire busy = (state_q == SRP_BURST);
  // Two beats may be in flight, so stall two entries short of full
  wire stall = !fifo_in_ready || (fifo_level >= `SRP_STALL_LEVEL);
  wire [`SRP_LANES-1:0] mask = lane_mask(ctl_q);
  wire mask_any = (mask != `SRP_MASK_NONE);
  wire start = strobe && ce_ok && !slp_s2_q && !stall;
  wire desel = (strobe && !ce_ok) || slp_s2_q;
  wire cont = busy && !strobe && !stall && !slp_s2_q;
  wire step = cont && !ctl_q.burst_advance_n;
  // A processor-strobe start is always a read cycle
  wire wr_beat = mask_any && ((start && ctl_q.proc_addr_strobe_n) || cont);
  wire rd_beat = (start && !wr_beat) || (step && !mask_any);
  wire beat = wr_beat || rd_beat;
  wire [`SRP_AW-1:2] beat_base = start ? ctl_q.addr[`SRP_AW-1:2] : base_q;
  wire [`SRP_MEM_AW-1:0] mem_idx = b_addr_q[`SRP_MEM_AW-1:0];

  assign o_dq = dout_q;
  assign o_dq_oe = rdv_q && !i_out_en_n && !i_sleep_request;
  assign o_port_stall = stall;

  // Pins are sampled once; the master is synchronous to this clock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_q <= '1;
      din_q <= '0;
    end else begin
      ctl_q <= i_ctl;
      din_q <= i_dq;
    end
  end

  // Sleep and order select are truly asynchronous levels
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slp_s1_q <= 1'b0;
      slp_s2_q <= 1'b0;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      slp_s1_q <= i_sleep_request;
      slp_s2_q <= slp_s1_q;
      mode_s1_q <= i_burst_linear;
      mode_s2_q <= mode_s1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SRP_IDLE: begin
        if (start) begin
          state_d = SRP_BURST;
        end
      end
      SRP_BURST: begin
        if (start) begin
          state_d = SRP_BURST;
        end else if (desel) begin
          state_d = SRP_IDLE;
        end
      end
      default: begin
        state_d = SRP_IDLE;
      end
    endcase
  end

  srp_burst_ctr u_ctr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_load(start),
    .i_step(step),
    .i_start_lo(ctl_q.addr[1:0]),
    .i_linear(mode_s2_q),
    .o_lo(ctr_lo),
    .o_cnt(ctr_cnt)
  );

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= SRP_IDLE;
      base_q <= '0;
    end else begin
      state_q <= state_d;
      if (start) begin
        base_q <= ctl_q.addr[`SRP_AW-1:2];
      end
    end
  end

  // Beat stage: address, lanes and data held for the array cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      b_addr_q <= '0;
      b_mask_q <= `SRP_MASK_NONE;
      b_data_q <= '0;
      b_rd_q <= 1'b0;
    end else begin
      if (beat) begin
        b_addr_q <= {beat_base, ctr_lo};
      end
      b_mask_q <= wr_beat ? mask : `SRP_MASK_NONE;
      b_data_q <= din_q;
      b_rd_q <= rd_beat;
    end
  end

  // Self-timed array write, one lane per loop pass
  always_ff @(posedge i_clk) begin
    for (int g = 0; g < `SRP_LANES; g++) begin
      if (b_mask_q[g]) begin
        mem[mem_idx][g*`SRP_LANE_W +: `SRP_LANE_W] <=
          b_data_q[g*`SRP_LANE_W +: `SRP_LANE_W];
      end
    end
  end

  // Output register: first beat lands three edges after the strobe cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dout_q <= '0;
      rdv_q <= 1'b0;
    end else begin
      if (b_rd_q) begin
        dout_q <= mem[mem_idx];
      end
      rdv_q <= b_rd_q;
    end
  end

  srp_fifo #(
    .WIDTH(`SRP_WORD_W),
    .DEPTH(`SRP_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_valid(rdv_q),
    .i_data(dout_q),
    .o_ready(fifo_in_ready),
    .o_valid(o_rd_valid),
    .o_data(o_rd_data),
    .i_ready(i_rd_ready),
    .o_level(fifo_level)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_start_read;
    start && rd_beat;
  endsequence

  sequence s_data_out;
    ##2 rdv_q;
  endsequence

  sequence s_step_read;
    step && !mask_any;
  endsequence

  sequence s_full_write;
    b_mask_q == `SRP_MASK_ALL;
  endsequence

  input_reg_a: assert property (ctl_q == $past(i_ctl))
    else $error("control inputs not registered");
  first_data_a: assert property (s_start_read |-> s_data_out)
    else $error("first read beat not two edges after start");
  next_data_a: assert property (s_step_read |-> s_data_out)
    else $error("burst beat not one cycle per advance");
  addr_latch_a: assert property (start |=> busy &&
                                 base_q == $past(ctl_q.addr[`SRP_AW-1:2]))
    else $error("address not latched on strobe");
  hold_cnt_a: assert property (!start && !step |=> $stable(ctr_cnt))
    else $error("counter moved without advance");
  cnt_step_a: assert property (step && !start |=>
                               ctr_cnt == $past(ctr_cnt) + 2'h1)
    else $error("counter did not wrap-step");

  // Order checks compare each beat with the one before it, so a mode change
  // in mid-burst is excluded; the bench changes mode only between bursts
  linear_seq_a: assert property (mode_s2_q && $stable(mode_s2_q) && step
                                 |=> b_addr_q[1:0] == $past(b_addr_q[1:0]) + 2'h1)
    else $error("linear order broken");
  interleave_seq_a: assert property (!mode_s2_q && $stable(mode_s2_q) && step
      |=> (b_addr_q[1:0] ^ $past(b_addr_q[1:0])) == (ctr_cnt ^ $past(ctr_cnt)))
    else $error("interleaved order broken");
  cnt_load_a: assert property (start |=>
                               b_addr_q[1:0] == $past(ctl_q.addr[1:0]))
    else $error("burst not started from low address bits");
  group_wrap_a: assert property (step |=>
                                 b_addr_q[`SRP_AW-1:2] == $past(b_addr_q[`SRP_AW-1:2]))
    else $error("burst carried out of its group");

  lane_write_a: assert property (wr_beat && ctl_q.all_bytes_write_n
                                 |=> b_mask_q == ~$past(ctl_q.byte_lane_write_n))
    else $error("wrong byte lanes written");
  global_write_a: assert property (wr_beat && !ctl_q.all_bytes_write_n |=>
                                   b_mask_q == `SRP_MASK_ALL)
    else $error("global write missed a lane");
  write_data_a: assert property (wr_beat |=> b_data_q == $past(din_q) && !b_rd_q)
    else $error("write data not held for array cycle");
  write_land_a: assert property (s_full_write |=>
                                 mem[$past(mem_idx)] == $past(b_data_q))
    else $error("full write did not land in array");
  proc_read_a: assert property (start && !ctl_q.proc_addr_strobe_n |-> rd_beat)
    else $error("processor strobe start not a read");

  // A word never written holds unknowns, so only written words may be read back
  read_data_a: assert property (b_rd_q |=> dout_q == $past(mem[mem_idx]))
    else $error("read word not registered to pins");
  dq_hold_a: assert property (!b_rd_q |=> $stable(dout_q))
    else $error("data pins changed without a read beat");
  fifo_room_a: assert property (rdv_q |-> fifo_in_ready)
    else $error("read beat offered to a full stream");
  async_oe_a: assert property (i_out_en_n || i_sleep_request |-> !o_dq_oe)
    else $error("data pins driven while disabled");
  oe_follow_a: assert property (rdv_q && !i_out_en_n && !i_sleep_request |-> o_dq_oe)
    else $error("data pins not driven for an enabled beat");
  ce_gate_a: assert property (strobe && !ce_ok |=> !busy)
    else $error("access started without chip enables");

  // Refused cycles must leave the array and the stream untouched
  idle_beat_a: assert property (!busy && !start |-> !beat)
    else $error("beat without an open burst");
  stall_hold_a: assert property (stall |-> !beat)
    else $error("beat taken while stalled");
  sleep_block_a: assert property (slp_s2_q |-> !beat ##1 !busy)
    else $error("access taken while asleep");
endmodule

// ---- rtl/srp_regs.svh ----
/*
  Constants of the pipelined sync SRAM port: widths, reset values and counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

`define SRP_AW 20
`define SRP_LANES 4
`define SRP_LANE_W 9
`define SRP_WORD_W 36
`define SRP_MEM_AW 8
`define SRP_FIFO_DEPTH 16
`define SRP_FIFO_CW 5
`define SRP_STALL_LEVEL 5'hE
`define SRP_MASK_ALL 4'hF
`define SRP_MASK_NONE 4'h0
`define SRP_CNT_ZERO 2'h0
`define SRP_CNT_ONE 2'h1
`define SRP_FIRST_DATA_CYC 3

`endif

// ---- verification/srp_master.sv ----
/*
  Bus master model: drives controls and write data one cycle at a time.
  Assumes the bench calls step once per cycle.
*/
module srp_master (
  // Clock
  input wire logic i_clk,
  // Bus drive
  output srp_pkg::srp_ctl_t o_ctl,
  output srp_pkg::srp_word_t o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  import srp_pkg::*;
  initial begin
    o_ctl = '1;
    o_dq = '0;
  end
  // Changes just after the edge and holds for the whole cycle
  task automatic step(input srp_ctl_t c, input logic wr, input srp_word_t d);
    @(posedge i_clk);
    #1;
    o_ctl = c;
    // Released data pins toggle so a stale write word cannot pass
    if (wr) o_dq = d;
    else o_dq = ~o_dq;
  endtask
endmodule

// ---- verification/tb_pipelined_sync_sram_port.sv ----
/*
  Self-checking bench of the SRAM port: writes, bursts, refusals, FIFO fill.
  Assumes srp_master drives the bus and a drain side stalls by i_rd_ready.
*/
module tb_pipelined_sync_sram_port;
  timeunit 1ns;
  timeprecision 100ps;
  import srp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_out_en_n = 1'b0;
  logic i_sleep_request = 1'b0;
  logic i_burst_linear = 1'b0;
  logic i_rd_ready = 1'b1;
  srp_ctl_t i_ctl;
  srp_word_t i_dq;
  srp_word_t o_dq;
  srp_word_t o_rd_data;
  logic o_dq_oe;
  logic o_rd_valid;
  logic o_port_stall;
  srp_word_t exp_m [256];
  int bad_count = 0;
  int compares = 0;
  int n;
  always #5 i_clk = ~i_clk;
  srp_master mst (.i_clk(i_clk), .o_ctl(i_ctl), .o_dq(i_dq));
  srp_port uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ctl(i_ctl), .i_dq(i_dq),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_out_en_n(i_out_en_n),
    .i_sleep_request(i_sleep_request), .i_burst_linear(i_burst_linear),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready),
    .o_port_stall(o_port_stall));

  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_w(input srp_word_t e, input srp_word_t g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: word %h, expected %h", $time, g, e);
    end
  endtask
  task automatic check_b(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: flag %b, expected %b", $time, g, e);
    end
  endtask
  task automatic check_n(input int e, input int g);
    compares++;
    if (g != e) begin
      bad_count++;
      $display("Error at %0t: count %0d, expected %0d", $time, g, e);
    end
  endtask
  function automatic srp_ctl_t mk(input logic [7:0] a, input logic ps_n, input logic cs_n,
      input logic adv_n, input logic ce, input logic [3:0] ln, input logic bwe_n,
      input logic gw_n);
    mk = '{{12'h000, a}, ps_n, cs_n, adv_n, ~ce, ce, ~ce, ln, bwe_n, gw_n};
  endfunction
  task automatic idle(input int c);
    repeat (c) mst.step(mk(8'h00, 1, 1, 1, 1, 4'hF, 1, 1), 0, '0);
  endtask
  // Expected array follows the lane rules: global write, else enabled lanes
  task automatic wr(input logic [7:0] a, input logic [3:0] ln, input logic bwe_n,
      input logic gw_n, input srp_word_t d);
    logic rd_only;
    rd_only = gw_n && (bwe_n || ln == 4'hF);
    mst.step(mk(a, 1, 0, 1, 1, ln, bwe_n, gw_n), 1, d);
    for (int k = 0; k < 4; k++)
      if (!gw_n || (!bwe_n && !ln[k])) exp_m[a][9*k +: 9] = d[9*k +: 9];
    idle(3);
    // With no lane selected the strobe opens a plain read of the word
    check_b(rd_only, o_dq_oe);
    if (rd_only) check_w(exp_m[a], o_dq);
  endtask
  task automatic rd(input logic [7:0] a, input logic ps, input int b);
    logic [1:0] lo;
    for (int i = 0; i < b + 3; i++) begin
      if (i == 0) mst.step(mk(a, ~ps, ps, 1, 1, 4'hF, 1, 1), 0, '0);
      else if (i < b) mst.step(mk(8'h00, 1, 1, 0, 1, 4'hF, 1, 1), 0, '0);
      else idle(1);
      if (i >= 3) begin
        lo = i_burst_linear ? a[1:0] + 2'(i - 3) : a[1:0] ^ 2'(i - 3);
        check_b(1'b1, o_dq_oe);
        check_w(exp_m[{a[7:2], lo}], o_dq);
      end
    end
    idle(1);
    check_b(1'b0, o_dq_oe);
  endtask
  // Processor strobe opens a read; write controls in the next cycle write that word
  task automatic t_proc_write(input logic [7:0] a, input srp_word_t d);
    mst.step(mk(a, 0, 1, 1, 1, 4'hF, 1, 1), 0, '0);
    mst.step(mk(8'h00, 1, 1, 1, 1, 4'hF, 1, 0), 1, d);
    exp_m[a] = d;
    idle(3);
    rd(a, 1, 1);
  endtask
  task automatic t_refused(input logic ce);
    mst.step(mk(8'h02, 0, 1, 1, ce, 4'hF, 1, 1), 0, '0);
    for (int i = 0; i < 4; i++) begin
      idle(1);
      check_b(1'b0, o_dq_oe);
    end
  endtask
  task automatic t_out_en();
    mst.step(mk(8'h03, 0, 1, 1, 1, 4'hF, 1, 1), 0, '0);
    idle(3);
    i_out_en_n = 1'b1;
    #1;
    check_b(1'b0, o_dq_oe);
    idle(1);
    i_out_en_n = 1'b0;
    check_b(1'b1, o_rd_valid);
    check_w(exp_m[3], o_rd_data);
    idle(2);
  endtask
  task automatic t_sleep();
    i_sleep_request = 1'b1;
    idle(3);
    t_refused(1'b1);
    check_b(1'b0, o_rd_valid);
    i_sleep_request = 1'b0;
    idle(3);
  endtask
  // Drain side stalls until the port refuses, then empties the FIFO
  task automatic t_fill();
    i_rd_ready = 1'b0;
    for (int i = 0; i < 14; i++) begin
      check_b(1'b0, o_port_stall);
      rd(8'h00, 1, 1);
    end
    check_b(1'b1, o_port_stall);
    t_refused(1'b1);
    i_rd_ready = 1'b1;
    n = 0;
    while (o_rd_valid === 1'b1 && n < 20) begin
      check_w(exp_m[0], o_rd_data);
      n++;
      idle(1);
    end
    check_n(14, n);
    check_b(1'b0, o_port_stall);
  endtask

  initial begin
    #100us;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    check_b(1'b0, o_dq_oe);
    check_b(1'b0, o_rd_valid);
    check_w('0, o_dq);
    i_rst_b = 1'b1;
    idle(2);
    for (int a = 0; a < 8; a++) wr(8'(a), 4'hF, 1, 0, {4{1'b1, 8'(a)}});
    wr(8'h05, 4'hE, 0, 0, 36'h123456789);
    wr(8'h04, 4'h3, 0, 1, 36'hAAAAAAAAA);
    wr(8'h04, 4'hE, 0, 1, 36'h555555555);
    wr(8'h04, 4'h0, 1, 1, 36'hFFFFFFFFF);
    rd(8'h04, 0, 1);
    rd(8'h05, 1, 1);
    rd(8'h01, 1, 4);
    rd(8'h06, 0, 4);
    idle(1);
    i_burst_linear = 1'b1;
    idle(3);
    rd(8'h01, 0, 4);
    rd(8'h07, 1, 4);
    rd(8'h02, 1, 2);
    t_proc_write(8'h06, 36'h13579BDF0);
    t_refused(1'b0);
    t_out_en();
    t_sleep();
    t_fill();
    finish_test();
  end
endmodule
